// file: core/obcd_defs.svh
// Purpose: named offsets, field positions and codes of the option byte decoder
// Assumes: included by the package and by the property and bench modules
// Notes: register offsets are word indexes; the byte address is four times the index
`ifndef OBCD_DEFS_SVH
`define OBCD_DEFS_SVH
`define OBCD_PADDR_W 12
`define OBCD_FLASH_AW 20
`define OBCD_IDX_DET 10'h0c1
`define OBCD_IDX_MODE 10'h0c2
`define OBCD_IDX_DBG 10'h0c3
`define OBCD_IDX_STATUS 10'h0c4
`define OBCD_IDX_ERR 10'h0c5
`define OBCD_FLASH_DET 20'h000c1
`define OBCD_FLASH_MODE 20'h000c2
`define OBCD_FLASH_DBG 20'h000c3
`define OBCD_DET_LVL 7:2
`define OBCD_DET_LVL_MASK 6'h3b
`define OBCD_DET_FIXED 4
`define OBCD_DET_MODE 1:0
`define OBCD_DET_COARSE2 7
`define OBCD_DET_ON_LVL_275 5'h0f
`define OBCD_DET_ON_LVL_286 5'h0e
`define OBCD_DET_ON_LVL_296 5'h0d
`define OBCD_DET_ON_LVL_306 5'h04
`define OBCD_MODE_INT_RST 2'h2
`define OBCD_MODE_RST 2'h3
`define OBCD_MODE_INT 2'h1
`define OBCD_MODE_OFF_BIT 0
`define OBCD_FM_FIELD 7:6
`define OBCD_FM_FIX 5:4
`define OBCD_FM_FIX_VAL 2'h2
`define OBCD_FM_FREQ 3:0
`define OBCD_FM_LS 2'h2
`define OBCD_FM_HS 2'h3
`define OBCD_LS_MAX_MHZ 6'h08
`define OBCD_DBG_EN 7
`define OBCD_DBG_ERS 0
`define OBCD_DBG_FIX 6:4
`define OBCD_DBG_FIX_VAL 3'h0
`define OBCD_ST_READY 0
`define OBCD_ST_ERR 1
`define OBCD_ST_AUTH 2
`define OBCD_ST_ERASE 3
`define OBCD_ST_FIXW 4
`define OBCD_ST_CNT 15:8
`endif

// file: core/obcd_pkg.sv
// Purpose: types shared by the option byte decoder modules
// Assumes: obcd_defs.svh on the include path
// Notes: all module state travels as packed structs declared here
`include "obcd_defs.svh"
package obcd_pkg;
	typedef enum logic [1:0] {
		OBCD_DET_INT_RST = 2'h0,
		OBCD_DET_RST = 2'h1,
		OBCD_DET_INT = 2'h2,
		OBCD_DET_OFF = 2'h3
	} obcd_det_mode_t;
	typedef enum logic [1:0] {
		OBCD_FLASH_BAD = 2'h0,
		OBCD_FLASH_LS = 2'h1,
		OBCD_FLASH_HS = 2'h2
	} obcd_flash_mode_t;
	typedef enum logic [2:0] {
		OBCD_F_IDLE = 3'h0,
		OBCD_F_DET = 3'h1,
		OBCD_F_MODE = 3'h3,
		OBCD_F_DBG = 3'h2,
		OBCD_F_DONE = 3'h6
	} obcd_fetch_state_t;
	typedef struct packed {
		logic [7:0] det;
		logic [7:0] mode;
		logic [7:0] dbg;
	} obcd_opt_bytes_t;
	typedef struct packed {
		obcd_det_mode_t det_mode;
		logic [1:0] det_level;
		logic det_int_en;
		logic det_rst_en;
		logic ext_reset_pin_en;
		obcd_flash_mode_t flash_mode;
		logic [5:0] osc_mhz;
		logic debug_enable;
		logic erase_suppress;
	} obcd_cfg_t;
	typedef struct packed {
		logic dbg;
		logic ls_freq;
		logic freq;
		logic flash;
		logic det;
	} obcd_err_t;
	typedef struct packed {
		obcd_fetch_state_t state;
		logic [`OBCD_FLASH_AW-1:0] addr;
		obcd_opt_bytes_t bytes;
	} obcd_fetch_st_t;
	typedef struct packed {
		obcd_cfg_t cfg;
		obcd_err_t err;
		logic fix_warn;
		logic cfg_valid;
		logic auth_seen;
		logic erase_seen;
		logic erase_req;
		logic [7:0] auth_cnt;
		logic [31:0] prdata;
		logic pslverr;
	} obcd_top_st_t;
endpackage : obcd_pkg

// file: core/obcd_fetch.sv
// Purpose: reads the three option bytes from flash once after reset
// Assumes: flash read port on sys_clk; ack is a one-cycle pulse with data
// Notes: never restarts until the next reset
`timescale 1ns/100ps
module obcd_fetch import obcd_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// flash read port
	output logic flash_rd_req,
	output logic [`OBCD_FLASH_AW-1:0] flash_rd_addr,
	input wire logic [7:0] flash_rd_data,
	input wire logic flash_rd_ack,
	// fetched bytes
	output obcd_opt_bytes_t bytes,
	output logic done
);
	obcd_fetch_st_t st;
	obcd_fetch_st_t next_st;

	always_comb begin
		next_st = st;
		case (st.state)
			OBCD_F_IDLE: begin
				next_st.state = OBCD_F_DET;
				next_st.addr = `OBCD_FLASH_DET;
			end
			OBCD_F_DET: if (flash_rd_ack) begin
				next_st.bytes.det = flash_rd_data;
				next_st.state = OBCD_F_MODE;
				next_st.addr = `OBCD_FLASH_MODE;
			end
			OBCD_F_MODE: if (flash_rd_ack) begin
				next_st.bytes.mode = flash_rd_data;
				next_st.state = OBCD_F_DBG;
				next_st.addr = `OBCD_FLASH_DBG;
			end
			OBCD_F_DBG: if (flash_rd_ack) begin
				next_st.bytes.dbg = flash_rd_data;
				next_st.state = OBCD_F_DONE;
			end
			OBCD_F_DONE: next_st.state = OBCD_F_DONE;
			default: next_st.state = OBCD_F_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flash_rd_req = (st.state == OBCD_F_DET) || (st.state == OBCD_F_MODE)
		|| (st.state == OBCD_F_DBG);
	assign flash_rd_addr = st.addr;
	assign bytes = st.bytes;
	assign done = (st.state == OBCD_F_DONE);
endmodule : obcd_fetch

// file: core/obcd_freq_lut.sv
// Purpose: maps the oscillator select code to a frequency in MHz
// Assumes: purely combinational
// Notes: unlisted codes return zero and flag invalid
`timescale 1ns/100ps
module obcd_freq_lut (
	// select code
	input wire logic [3:0] code,
	// result
	output logic [5:0] mhz,
	output logic valid
);
	always_comb begin
		valid = 1'b1;
		case (code)
			4'h8: mhz = 6'h20;
			4'h0: mhz = 6'h18;
			4'h9: mhz = 6'h10;
			4'h1: mhz = 6'h0c;
			4'ha: mhz = 6'h08;
			4'h2: mhz = 6'h06;
			4'hb: mhz = 6'h04;
			4'h3: mhz = 6'h03;
			4'hc: mhz = 6'h02;
			4'hd: mhz = 6'h01;
			default: begin
				mhz = 6'h00;
				valid = 1'b0;
			end
		endcase
	end
endmodule : obcd_freq_lut

// file: core/obcd_top.sv
// Purpose: option byte decoder: fetch, decode, hold and expose reset-time configuration
// Assumes: APB slave on sys_clk, zero wait states; flash port and auth pulse on sys_clk
// Notes: decoded settings are frozen from the first valid capture until reset
// Operation
// - fetch option bytes after every reset and apply before releasing the cpu
// - detector byte: coarse bits 7-5, fixed bit 4, fine 3-2, mode 1-0
// - four detector modes: interrupt and reset, reset, interrupt, off
// - interrupt mode four thresholds; mode bit0 with coarse bit2 means off
// - flash mode from bits 7-6, oscillator select from bits 3-0
// - flash mode 10 is low-speed main, 1 to 8 MHz
// - flash mode 11 is high-speed main, 1 to 32 MHz; 00, 01 prohibited
// - ten oscillator codes map to 32 down to 1 MHz; others prohibited
// - enable 0 erase-suppress 0 disables debug; 0 with 1 is prohibited
// - enable with erase-suppress clear erases flash on authentication failure
// - enable with erase-suppress set keeps flash on authentication failure
// - debug byte bits 3-1 may be overwritten while debugging; not checked
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module obcd_top import obcd_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic [`OBCD_PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// flash read port
	output logic flash_rd_req,
	output logic [`OBCD_FLASH_AW-1:0] flash_rd_addr,
	input wire logic [7:0] flash_rd_data,
	input wire logic flash_rd_ack,
	// debugger authentication
	input wire logic debug_auth_fail,
	output logic flash_erase_req,
	// decoded configuration
	output obcd_cfg_t cfg,
	output logic cfg_error,
	output logic cpu_release
);
	obcd_top_st_t st;
	obcd_top_st_t next_st;
	obcd_opt_bytes_t bytes;
	logic fetch_done;
	logic [5:0] lut_mhz;
	logic lut_valid;
	obcd_cfg_t dec_cfg;
	obcd_err_t dec_err;
	logic dec_fix_warn;
	logic [5:0] det_lvl;
	logic [1:0] det_mode_bits;
	logic [1:0] fm_bits;
	logic setup_phase;
	logic access_phase;
	logic [9:0] word_idx;
	logic idx_hit;
	logic [31:0] rd_word;
	logic rd_hit;

	obcd_fetch u_fetch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flash_rd_req(flash_rd_req),
		.flash_rd_addr(flash_rd_addr),
		.flash_rd_data(flash_rd_data),
		.flash_rd_ack(flash_rd_ack),
		.bytes(bytes),
		.done(fetch_done)
	);

	obcd_freq_lut u_freq (
		.code(bytes.mode[`OBCD_FM_FREQ]),
		.mhz(lut_mhz),
		.valid(lut_valid)
	);

	assign det_lvl = bytes.det[`OBCD_DET_LVL] & `OBCD_DET_LVL_MASK; // drop fixed bit 4 from the match
	assign det_mode_bits = bytes.det[`OBCD_DET_MODE];
	assign fm_bits = bytes.mode[`OBCD_FM_FIELD];

	// detector byte decode; bit 4 is masked so a bad fixed bit only warns
	always_comb begin
		logic [4:0] lvl5;
		logic lvl_ok;
		lvl5 = {det_lvl[5:3], det_lvl[1:0]};
		lvl_ok = 1'b1;
		dec_cfg = '0;
		dec_err = '0;
		case (lvl5)
			`OBCD_DET_ON_LVL_275: dec_cfg.det_level = 2'h0;
			`OBCD_DET_ON_LVL_286: dec_cfg.det_level = 2'h1;
			`OBCD_DET_ON_LVL_296: dec_cfg.det_level = 2'h2;
			`OBCD_DET_ON_LVL_306: dec_cfg.det_level = 2'h3;
			default: lvl_ok = 1'b0;
		endcase
		if (det_mode_bits[`OBCD_MODE_OFF_BIT] && bytes.det[`OBCD_DET_COARSE2]) begin
			// off: the external reset pin takes over
			dec_cfg.det_mode = OBCD_DET_OFF;
			dec_cfg.det_level = 2'h0;
			dec_cfg.ext_reset_pin_en = 1'b1;
		end else begin
			case (det_mode_bits)
				`OBCD_MODE_INT: begin
					dec_cfg.det_mode = OBCD_DET_INT;
					dec_cfg.det_int_en = 1'b1;
					dec_err.det = !lvl_ok;
				end
				`OBCD_MODE_RST: begin
					dec_cfg.det_mode = OBCD_DET_RST;
					dec_cfg.det_rst_en = 1'b1;
					dec_err.det = !lvl_ok;
				end
				`OBCD_MODE_INT_RST: begin
					// only the two middle levels exist in this mode
					dec_cfg.det_mode = OBCD_DET_INT_RST;
					dec_cfg.det_int_en = 1'b1;
					dec_cfg.det_rst_en = 1'b1;
					dec_err.det = !(lvl5 == `OBCD_DET_ON_LVL_286 ||
						lvl5 == `OBCD_DET_ON_LVL_296);
				end
				default: begin
					dec_cfg.det_mode = OBCD_DET_OFF;
					dec_cfg.ext_reset_pin_en = 1'b1;
					dec_err.det = 1'b1;
				end
			endcase
		end

		// flash mode and oscillator
		case (fm_bits)
			`OBCD_FM_LS: dec_cfg.flash_mode = OBCD_FLASH_LS;
			`OBCD_FM_HS: dec_cfg.flash_mode = OBCD_FLASH_HS;
			default: begin
				dec_cfg.flash_mode = OBCD_FLASH_BAD;
				dec_err.flash = 1'b1;
			end
		endcase
		dec_cfg.osc_mhz = lut_mhz;
		dec_err.freq = !lut_valid;
		dec_err.ls_freq = (fm_bits == `OBCD_FM_LS) && lut_valid &&
			(lut_mhz > `OBCD_LS_MAX_MHZ);

		// debug byte: bits 3-1 are ignored since the debugger may rewrite them
		case ({bytes.dbg[`OBCD_DBG_EN], bytes.dbg[`OBCD_DBG_ERS]})
			2'h0: begin
				dec_cfg.debug_enable = 1'b0;
				dec_cfg.erase_suppress = 1'b0;
			end
			2'h2: begin
				dec_cfg.debug_enable = 1'b1;
				dec_cfg.erase_suppress = 1'b0;
			end
			2'h3: begin
				dec_cfg.debug_enable = 1'b1;
				dec_cfg.erase_suppress = 1'b1;
			end
			default: begin
				// prohibited: keep debug off and flag it
				dec_cfg.debug_enable = 1'b0;
				dec_cfg.erase_suppress = 1'b0;
				dec_err.dbg = 1'b1;
			end
		endcase
	end

	// fixed-bit mismatches are the programmer's fault; warned, not an error
	assign dec_fix_warn = !bytes.det[`OBCD_DET_FIXED]
		|| (bytes.mode[`OBCD_FM_FIX] != `OBCD_FM_FIX_VAL)
		|| (bytes.dbg[`OBCD_DBG_FIX] != `OBCD_DBG_FIX_VAL);

	// apb decode
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign word_idx = paddr[`OBCD_PADDR_W-1:2];
	assign idx_hit = (word_idx == `OBCD_IDX_DET) || (word_idx == `OBCD_IDX_MODE)
		|| (word_idx == `OBCD_IDX_DBG) || (word_idx == `OBCD_IDX_STATUS)
		|| (word_idx == `OBCD_IDX_ERR);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (word_idx)
			`OBCD_IDX_DET: rd_word[7:0] = bytes.det;
			`OBCD_IDX_MODE: rd_word[7:0] = bytes.mode;
			`OBCD_IDX_DBG: rd_word[7:0] = bytes.dbg;
			`OBCD_IDX_STATUS: begin
				rd_word[`OBCD_ST_READY] = st.cfg_valid;
				rd_word[`OBCD_ST_ERR] = |st.err;
				rd_word[`OBCD_ST_AUTH] = st.auth_seen;
				rd_word[`OBCD_ST_ERASE] = st.erase_seen;
				rd_word[`OBCD_ST_FIXW] = st.fix_warn;
				rd_word[`OBCD_ST_CNT] = st.auth_cnt;
			end
			`OBCD_IDX_ERR: rd_word[4:0] = st.err;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		logic auth_ev;
		logic clr_auth;
		logic clr_erase;
		auth_ev = 1'b0;
		clr_auth = 1'b0;
		clr_erase = 1'b0;
		next_st = st;
		next_st.erase_req = 1'b0;

		// single capture; settings never move again until reset
		if (fetch_done && !st.cfg_valid) begin
			next_st.cfg = dec_cfg;
			next_st.err = dec_err;
			next_st.fix_warn = dec_fix_warn;
			next_st.cfg_valid = 1'b1;
		end

		// authentication failures only matter once debugging is enabled
		if (st.cfg_valid && st.cfg.debug_enable && debug_auth_fail) begin
			auth_ev = 1'b1;
			next_st.erase_req = !st.cfg.erase_suppress;
			if (st.auth_cnt != 8'hff) begin
				next_st.auth_cnt = st.auth_cnt + 8'h01;
			end
		end

		// register reads are latched in the setup cycle, so zero wait states
		if (setup_phase) begin
			next_st.prdata = pwrite ? 32'h0000_0000 : rd_word;
			next_st.pslverr = pwrite ? !idx_hit : !rd_hit;
		end

		// the auth and erase status flags are write-one-to-clear through byte lane 0
		if (access_phase && pwrite && pstrb[0] && word_idx == `OBCD_IDX_STATUS) begin
			clr_auth = pwdata[`OBCD_ST_AUTH];
			clr_erase = pwdata[`OBCD_ST_ERASE];
		end
		if (clr_auth) begin
			next_st.auth_seen = 1'b0;
		end
		if (clr_erase) begin
			next_st.erase_seen = 1'b0;
		end
		// a new event in the clearing cycle wins over the clear
		if (auth_ev) begin
			next_st.auth_seen = 1'b1;
			if (!st.cfg.erase_suppress) begin
				next_st.erase_seen = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pready = access_phase;
	assign prdata = st.prdata;
	assign pslverr = access_phase && st.pslverr;
	assign flash_erase_req = st.erase_req;
	assign cfg = st.cfg;
	assign cfg_error = st.cfg_valid && (|st.err);
	assign cpu_release = st.cfg_valid;
endmodule : obcd_top

// file: verif/obcd_top_props.sv
// Purpose: concurrent checks on the option byte decoder ports
// Assumes: one clock domain, async active-low reset
// Notes: attached to obcd_top by the bind at the foot
`timescale 1ns/100ps
`include "obcd_defs.svh"
module obcd_top_props import obcd_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// flash read port
	input wire logic flash_rd_req,
	input wire logic [`OBCD_FLASH_AW-1:0] flash_rd_addr,
	input wire logic flash_rd_ack,
	// authentication and configuration
	input wire logic debug_auth_fail,
	input wire logic flash_erase_req,
	input wire obcd_cfg_t cfg,
	input wire logic cfg_error,
	input wire logic cpu_release
);
	logic erase_cause;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a failed authentication only erases when debugging is on and erasing allowed
	assign erase_cause = debug_auth_fail & cpu_release & cfg.debug_enable & ~cfg.erase_suppress;
	AST_FETCH_ORDER: assert property (flash_rd_req && flash_rd_ack
		&& flash_rd_addr == 20'h000c1 |=> flash_rd_req && flash_rd_addr == 20'h000c2)
		else $error("second byte not fetched after first");
	AST_FETCH_END: assert property (flash_rd_req && flash_rd_ack
		&& flash_rd_addr == 20'h000c3 |=> !flash_rd_req ##1 cpu_release)
		else $error("release does not follow last byte");
	AST_NO_REFETCH: assert property (cpu_release |-> !flash_rd_req)
		else $error("fetch after release");
	AST_RELEASE_HOLD: assert property (cpu_release |=> cpu_release)
		else $error("release dropped without reset");
	AST_CFG_HOLD: assert property (cpu_release && $past(cpu_release)
		|-> $stable(cfg) && $stable(cfg_error))
		else $error("settings changed after capture");
	AST_ERASE_GO: assert property (erase_cause |=> flash_erase_req)
		else $error("erase missing after failed authentication");
	AST_ERASE_CAUSE: assert property (flash_erase_req |-> $past(erase_cause))
		else $error("erase without cause");
	AST_LS_LIMIT: assert property (cpu_release && cfg.flash_mode == OBCD_FLASH_LS
		&& cfg.osc_mhz > 6'h08 |-> cfg_error)
		else $error("low speed above limit not flagged");
	AST_BAD_FLASH: assert property (cpu_release
		&& cfg.flash_mode == OBCD_FLASH_BAD |-> cfg_error)
		else $error("prohibited flash mode not flagged");
	AST_OSC_SET: assert property (cpu_release |-> cfg.osc_mhz inside
		{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20})
		else $error("oscillator value outside the table");
	cover property ($rose(cpu_release));
	cover property (flash_erase_req);
	cover property (cpu_release && cfg_error);
endmodule : obcd_top_props

bind obcd_top obcd_top_props props_u (.sys_clk, .rst_n, .flash_rd_req, .flash_rd_addr,
	.flash_rd_ack, .debug_auth_fail, .flash_erase_req, .cfg, .cfg_error, .cpu_release);

// file: verif/obcd_top_tb.sv
// Purpose: self-checking bench for the option byte decoder
// Assumes: the bench answers the flash port with random stalls
// Notes: every pass resets, serves fresh bytes and checks the decode
`timescale 1ns/100ps
`include "obcd_defs.svh"
module obcd_top_tb import obcd_pkg::*;;
	logic sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic flash_rd_ack = 1'h0, debug_auth_fail = 1'h0, pready, pslverr, er;
	logic flash_rd_req, flash_erase_req, cfg_error, cpu_release;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h2006;
	logic [7:0] flash_rd_data = 8'h00;
	logic [7:0] img [4];
	logic [7:0] dtab [9] = '{8'h7a, 8'h76, 8'h7e, 8'h7f, 8'h33, 8'h7d, 8'h31, 8'h95, 8'h78};
	logic [2:0] entab [4] = '{3'h6, 3'h2, 3'h4, 3'h1};
	logic [19:0] flash_rd_addr;
	obcd_cfg_t cfg;
	int err_total = 0, num_checks = 0, nb = 0, ne = 0;
	obcd_top dut_u (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb(4'hf), .pready, .prdata, .pslverr, .flash_rd_req, .flash_rd_addr,
		.flash_rd_data, .flash_rd_ack, .debug_auth_fail, .flash_erase_req, .cfg,
		.cfg_error, .cpu_release);
	initial forever #4 sys_clk = ~sys_clk;
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [5:0] mhz(logic [3:0] c);
		case (c)
			4'h8: return 6'h20;
			4'h0: return 6'h18;
			4'h9: return 6'h10;
			4'h1: return 6'h0c;
			4'ha: return 6'h08;
			4'h2: return 6'h06;
			4'hb: return 6'h04;
			4'h3: return 6'h03;
			4'hc: return 6'h02;
			4'hd: return 6'h01;
			default: return 6'h00;
		endcase
	endfunction : mhz
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			err_total++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// erase pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge sys_clk) begin
		ne <= (rst_n === 1'h0) ? 0 : ne + (flash_erase_req === 1'h1);
	end
	// released data lines toggle so a stale byte never looks valid
	always @(posedge sys_clk) begin
		lfsr <= nxt(lfsr);
		flash_rd_ack <= 1'h0;
		flash_rd_data <= ~flash_rd_data;
		if (flash_rd_req === 1'h1 && !flash_rd_ack && lfsr[0]) begin
			chk(flash_rd_addr, 20'h000c1 + nb);
			flash_rd_ack <= 1'h1;
			flash_rd_data <= img[flash_rd_addr[1:0]];
			nb++;
		end
	end
	initial begin
		logic [7:0] d, m, g;
		logic [4:0] e, lv;
		logic [1:0] dm;
		logic warn;
		int k;
		for (int i = 0; i < 40; i++) begin
			rst_n <= 1'h0;
			repeat (8) @(posedge sys_clk);
			d = lfsr[7:0];
			m = lfsr[15:8];
			g = lfsr[23:16];
			if (i < 16) begin
				d = dtab[i % 9];
				m = {1'h1, i[0], 2'h2, i[3:0]};
				g = {i[1], 6'h02, i[2]};
			end
			img[1] = d;
			img[2] = m;
			img[3] = g;
			nb = 0;
			rst_n <= 1'h1;
			for (k = 0; k < 100 && cpu_release !== 1'h1; k++) @(posedge sys_clk);
			if (cpu_release !== 1'h1) begin
				err_total++;
				report_and_stop();
			end
			lv = {d[7:5], d[3:2]};
			dm = (d[0] & d[7]) ? 2'h3 : d[1] ? {1'h0, d[0]} : 2'h2;
			e[0] = (d[0] & d[7]) ? 1'h0 : (d[1:0] == 2'h2) ? !(lv inside {5'h0e, 5'h0d}) :
				(d[1:0] == 2'h0) ? 1'h1 : !(lv inside {5'h0f, 5'h0e, 5'h0d, 5'h04});
			e[1] = !m[7];
			e[2] = mhz(m[3:0]) == 6'h00;
			e[3] = m[7:6] == 2'h2 && mhz(m[3:0]) > 6'h08;
			e[4] = g[0] & !g[7];
			warn = !d[4] | (m[5:4] != 2'h2) | (g[6:4] != 3'h0);
			chk(cfg_error, |e);
			chk(cfg.osc_mhz, mhz(m[3:0]));
			chk(cfg.flash_mode, m[7] ? {m[6], !m[6]} : 2'h0);
			chk(cfg.debug_enable, g[7]);
			if (g[7]) chk(cfg.erase_suppress, g[0]);
			if (!e[0]) chk(cfg.det_mode, dm);
			if (!e[0]) chk({cfg.det_int_en, cfg.det_rst_en, cfg.ext_reset_pin_en}, entab[dm]);
			if (!e[0] && dm != 2'h3) chk(cfg.det_level, lv == 5'h0f ? 2'h0 : lv == 5'h0e ? 2'h1 :
				lv == 5'h0d ? 2'h2 : 2'h3);
			for (k = 1; k < 4; k++) begin
				apb(1'h1, 12'h300 + 12'(k * 4), 32'hffffffff);
				apb(1'h0, 12'h300 + 12'(k * 4), 32'h0);
				chk(rd, {24'h0, img[k]});
			end
			apb(1'h0, 12'h314, 32'h0);
			chk(rd, {27'h0, e});
			@(posedge sys_clk);
			debug_auth_fail <= 1'h1;
			repeat (2) @(posedge sys_clk);
			debug_auth_fail <= 1'h0;
			repeat (3) @(posedge sys_clk);
			chk(ne, (g[7] & !g[0]) ? 2 : 0);
			apb(1'h0, 12'h310, 32'h0);
			chk(rd, {16'h0, g[7] ? 8'h02 : 8'h00, 3'h0, warn, g[7] & !g[0], g[7], |e, 1'h1});
			apb(1'h1, 12'h310, 32'h0c);
			apb(1'h0, 12'h310, 32'h0);
			chk(rd[3:2], 2'h0);
			apb(1'h0, 12'h318, 32'h0);
			chk(er, 1'h1);
			chk(rd, 32'h0);
		end
		report_and_stop();
	end
endmodule : obcd_top_tb
